//--- msp_config_bank.sv
// Configuration bank and derived motor control outputs.
// Assumes a serial front end gives one-cycle write and read strobes.
`timescale 1ns/1ps
module msp_config_bank #(
   parameter int SPEED_W = 12,
   parameter int CURR_W  = 12,
   parameter int PHASES  = 3
) (
   input  wire logic               clk_sys,
   input  wire logic               sys_rst,
   input  wire logic [7:0]         reg_addr,
   input  wire logic [7:0]         reg_wdata,
   input  wire logic               reg_wr,
   input  wire logic               reg_rd,
   output logic      [7:0]         reg_rdata,
   output logic                    reg_rvalid,
   input  wire logic [SPEED_W-1:0] motor_speed,
   input  wire logic [CURR_W-1:0]  phase_current,
   input  wire logic               start_req,
   input  wire logic               stop_req,
   input  wire logic               no_motor_det,
   input  wire logic               kt_abnormal_det,
   input  wire logic               speed_abnormal_det,
   input  wire logic               zero_cross_missing,
   input  wire logic               sense_done,
   input  wire logic [PHASES-1:0]  gate_hs_req,
   input  wire logic [PHASES-1:0]  gate_ls_req,
   output logic      [15:0]        second_order_accel,
   output logic      [15:0]        first_order_accel,
   output logic      [SPEED_W-1:0] loop_handover_threshold,
   output logic                    open_loop_active,
   output logic                    closed_loop_active,
   output logic                    accel_limit_hit,
   output logic                    lock_current_fault,
   output logic                    no_motor_fault,
   output logic                    kt_lock_fault,
   output logic                    speed_lock_fault,
   output logic                    closed_stuck_fault,
   output logic                    open_stuck_fault,
   output logic                    mechanical_surge_enable,
   output logic                    mechanical_surge_mode,
   output logic                    release_brake,
   output logic                    release_hiz,
   output logic      [PHASES-1:0]  gate_hs,
   output logic      [PHASES-1:0]  gate_ls
);

   if (SPEED_W < 12) begin : g_chk_speed
      $error("SPEED_W must be at least 12");
   end
   if (CURR_W < 12) begin : g_chk_curr
      $error("CURR_W must be at least 12");
   end
   if (PHASES < 1) begin : g_chk_ph
      $error("PHASES must be at least 1");
   end

   // ---
   // Register file
   // ---
   logic [7:0] startup_accel_config;
   logic [7:0] loop_handover_align_config;
   logic [7:0] fault_enable_config;
   logic [7:0] current_limit_config;
   logic [7:0] closed_loop_deadtime_config;
   logic [7:0] open_loop_stuck_config;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         startup_accel_config        <= msp_pkg::RST_STARTUP_ACCEL;
         loop_handover_align_config  <= msp_pkg::RST_HANDOVER_ALIGN;
         fault_enable_config         <= msp_pkg::RST_FAULT_ENABLE;
         current_limit_config        <= msp_pkg::RST_CURRENT_LIMIT;
         closed_loop_deadtime_config <= msp_pkg::RST_CLOSED_DEADTIME;
         open_loop_stuck_config      <= msp_pkg::RST_OPEN_STUCK;
      end else if (reg_wr) begin
         case (reg_addr)
            msp_pkg::ADDR_STARTUP_ACCEL:   startup_accel_config        <= reg_wdata;
            msp_pkg::ADDR_HANDOVER_ALIGN:  loop_handover_align_config  <= reg_wdata;
            msp_pkg::ADDR_FAULT_ENABLE:    fault_enable_config         <= reg_wdata;
            msp_pkg::ADDR_CURRENT_LIMIT:   current_limit_config        <= reg_wdata;
            msp_pkg::ADDR_CLOSED_DEADTIME: closed_loop_deadtime_config <= reg_wdata;
            msp_pkg::ADDR_OPEN_STUCK:      open_loop_stuck_config      <= reg_wdata;
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         reg_rdata  <= msp_pkg::UNMAPPED_DATA;
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_rd;
         if (reg_rd) begin
            case (reg_addr)
               msp_pkg::ADDR_STARTUP_ACCEL:   reg_rdata <= startup_accel_config;
               msp_pkg::ADDR_HANDOVER_ALIGN:  reg_rdata <= loop_handover_align_config;
               msp_pkg::ADDR_FAULT_ENABLE:    reg_rdata <= fault_enable_config;
               msp_pkg::ADDR_CURRENT_LIMIT:   reg_rdata <= current_limit_config;
               msp_pkg::ADDR_CLOSED_DEADTIME: reg_rdata <= closed_loop_deadtime_config;
               msp_pkg::ADDR_OPEN_STUCK:      reg_rdata <= open_loop_stuck_config;
               default:                       reg_rdata <= msp_pkg::UNMAPPED_DATA;
            endcase
         end
      end
   end

   // ---
   // Start-up acceleration tables (0.01 units)
   // ---
   function automatic logic [15:0] second_rate(input logic [2:0] code);
      case (code)
         3'd0:    second_rate = 16'd5700;
         3'd1:    second_rate = 16'd2900;
         3'd2:    second_rate = 16'd1400;
         3'd3:    second_rate = 16'd690;
         3'd4:    second_rate = 16'd330;
         3'd5:    second_rate = 16'd160;
         3'd6:    second_rate = 16'd66;
         default: second_rate = 16'd22;
      endcase
   endfunction

   function automatic logic [15:0] first_rate(input logic [2:0] code);
      case (code)
         3'd0:    first_rate = 16'd7600;
         3'd1:    first_rate = 16'd3800;
         3'd2:    first_rate = 16'd1900;
         3'd3:    first_rate = 16'd920;
         3'd4:    first_rate = 16'd450;
         3'd5:    first_rate = 16'd210;
         3'd6:    first_rate = 16'd90;
         default: first_rate = 16'd30;
      endcase
   endfunction

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         second_order_accel <= 16'h0000;
         first_order_accel  <= 16'h0000;
      end else begin
         second_order_accel <= second_rate(
            startup_accel_config[msp_pkg::SECOND_ACCEL_LSB +: 3]);
         first_order_accel  <= first_rate(
            startup_accel_config[msp_pkg::FIRST_ACCEL_LSB +: 3]);
      end
   end

   // ---
   // Handover threshold (0.1 Hz units)
   // ---
   logic [4:0]  handover_code;
   logic [11:0] next_threshold;
   logic        threshold_valid;

   assign handover_code   = loop_handover_align_config[msp_pkg::HANDOVER_LSB +: 5];
   assign threshold_valid = handover_code != 5'h00;

   always_comb begin
      if (handover_code[4]) begin
         next_threshold = 12'({8'h00, handover_code[3:0]} + 12'h001)
                          * msp_pkg::HANDOVER_STEP_HI;
      end else begin
         next_threshold = 12'({8'h00, handover_code[3:0]} * msp_pkg::HANDOVER_STEP_LO);
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         loop_handover_threshold <= '0;
      end else begin
         loop_handover_threshold <= SPEED_W'(next_threshold);
      end
   end

   // ---
   // Loop state
   // ---
   msp_pkg::msp_loop_t loop_state;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         loop_state <= msp_pkg::ST_IDLE;
      end else if (stop_req) begin
         loop_state <= msp_pkg::ST_IDLE;
      end else begin
         case (loop_state)
            msp_pkg::ST_IDLE:
               if (start_req) begin
                  loop_state <= msp_pkg::ST_OPEN;
               end
            msp_pkg::ST_OPEN:
               if (threshold_valid && motor_speed >= SPEED_W'(next_threshold)) begin
                  loop_state <= msp_pkg::ST_CLOSED;
               end
            msp_pkg::ST_CLOSED: ;
            default: loop_state <= msp_pkg::ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         open_loop_active   <= 1'b0;
         closed_loop_active <= 1'b0;
      end else begin
         open_loop_active   <= loop_state == msp_pkg::ST_OPEN;
         closed_loop_active <= loop_state == msp_pkg::ST_CLOSED;
      end
   end

   // ---
   // Current limits (mA)
   // ---
   logic [3:0]  accel_ilim_code;
   logic [2:0]  lock_ilim_code;
   logic [11:0] accel_ilim_ma;
   logic [11:0] lock_ilim_ma;

   assign accel_ilim_code = current_limit_config[msp_pkg::ACCEL_ILIM_LSB +: 4];
   assign lock_ilim_code  = current_limit_config[msp_pkg::LOCK_ILIM_LSB +: 3];
   assign accel_ilim_ma   = 12'({8'h00, accel_ilim_code} * msp_pkg::ACCEL_ILIM_STEP);
   assign lock_ilim_ma    = 12'(({9'h000, lock_ilim_code} + 12'h001)
                                * msp_pkg::LOCK_ILIM_STEP);

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         accel_limit_hit    <= 1'b0;
         lock_current_fault <= 1'b0;
      end else begin
         accel_limit_hit    <= (accel_ilim_code != 4'h0) && open_loop_active
                               && (phase_current >= CURR_W'(accel_ilim_ma));
         lock_current_fault <= fault_enable_config[msp_pkg::BIT_CURR_LOCK]
                               && (phase_current >= CURR_W'(lock_ilim_ma));
      end
   end

   // ---
   // Fault gating
   // ---
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         no_motor_fault     <= 1'b0;
         kt_lock_fault      <= 1'b0;
         speed_lock_fault   <= 1'b0;
         closed_stuck_fault <= 1'b0;
         open_stuck_fault   <= 1'b0;
      end else begin
         no_motor_fault     <= no_motor_det
                               & fault_enable_config[msp_pkg::BIT_NO_MOTOR];
         kt_lock_fault      <= kt_abnormal_det
                               & fault_enable_config[msp_pkg::BIT_KT_LOCK];
         speed_lock_fault   <= speed_abnormal_det
                               & fault_enable_config[msp_pkg::BIT_SPEED_LOCK];
         closed_stuck_fault <= zero_cross_missing & closed_loop_active
                               & closed_loop_deadtime_config[msp_pkg::BIT_CLOSED_STUCK];
         open_stuck_fault   <= zero_cross_missing & open_loop_active
                               & open_loop_stuck_config[msp_pkg::BIT_OPEN_STUCK];
      end
   end

   // ---
   // Surge protection and sense release
   // ---
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         mechanical_surge_enable <= 1'b0;
         mechanical_surge_mode   <= 1'b0;
      end else begin
         // Inductive surge bit drives nothing
         mechanical_surge_enable <= fault_enable_config[msp_pkg::BIT_MECH_SURGE];
         mechanical_surge_mode   <= fault_enable_config[msp_pkg::BIT_MECH_SURGE_MD];
      end
   end

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         release_brake <= 1'b0;
         release_hiz   <= 1'b0;
      end else begin
         release_brake <= sense_done & ~fault_enable_config[msp_pkg::BIT_RELEASE_MODE];
         release_hiz   <= sense_done &  fault_enable_config[msp_pkg::BIT_RELEASE_MODE];
      end
   end

   // ---
   // Dead time per phase
   // ---
   logic [3:0] dead_code;
   logic [7:0] dead_cycles;

   assign dead_code   = closed_loop_deadtime_config[msp_pkg::DEADTIME_LSB +: 4];
   assign dead_cycles = 8'(({4'h0, dead_code} + 8'h01) * 8'(msp_pkg::DT_STEP_CYC));

   for (genvar ph = 0; ph < PHASES; ph++) begin : g_phase
      msp_dead_time #(
         .CNT_W       (8)
      ) u_dead (
         .clk_sys     (clk_sys),
         .sys_rst     (sys_rst),
         .dead_cycles (dead_cycles),
         .hs_req      (gate_hs_req[ph]),
         .ls_req      (gate_ls_req[ph]),
         .hs_out      (gate_hs[ph]),
         .ls_out      (gate_ls[ph])
      );
   end

endmodule

//--- msp_config_bank_chk.sv
// Port checker for the configuration bank.
// Assumes a bind into msp_config_bank, one synchronous reset.
`timescale 1ns/1ps
module msp_config_bank_chk #(
   parameter int SPEED_W = 12,
   parameter int CURR_W  = 12,
   parameter int PHASES  = 3
) (
   input wire logic              clk_sys,
   input wire logic              sys_rst,
   input wire logic [7:0]        reg_addr,
   input wire logic [7:0]        reg_wdata,
   input wire logic              reg_wr,
   input wire logic              reg_rd,
   input wire logic              reg_rvalid,
   input wire logic [CURR_W-1:0] phase_current,
   input wire logic              no_motor_det,
   input wire logic              kt_abnormal_det,
   input wire logic              speed_abnormal_det,
   input wire logic              zero_cross_missing,
   input wire logic              sense_done,
   input wire logic              no_motor_fault,
   input wire logic              kt_lock_fault,
   input wire logic              speed_lock_fault,
   input wire logic              lock_current_fault,
   input wire logic              closed_stuck_fault,
   input wire logic              release_brake,
   input wire logic              release_hiz,
   input wire logic              open_loop_active,
   input wire logic              closed_loop_active,
   input wire logic [PHASES-1:0] gate_hs,
   input wire logic [PHASES-1:0] gate_ls
);
   // ---
   // Shadows
   // ---
   logic [7:0] fe, lim, cl, ho, off_cnt;
   logic       last_hs, cur_hit;
   int         dt_min;
   assign cur_hit = int'(phase_current) >= (int'(lim[3:1]) + 1) * 400;
   assign dt_min  = (int'(cl[3:0]) + 1) * 10 - 1;
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         fe  <= 8'h00;
         lim <= 8'h00;
         cl  <= 8'h00;
         ho  <= 8'h00;
      end else if (reg_wr) begin
         case (reg_addr)
            msp_pkg::ADDR_FAULT_ENABLE:    fe  <= reg_wdata;
            msp_pkg::ADDR_CURRENT_LIMIT:   lim <= reg_wdata;
            msp_pkg::ADDR_CLOSED_DEADTIME: cl  <= reg_wdata;
            msp_pkg::ADDR_HANDOVER_ALIGN:  ho  <= reg_wdata;
            default: ;
         endcase
      end
   end
   // All-off cycles of phase 0
   always_ff @(posedge clk_sys) begin
      if (sys_rst || gate_hs[0] || gate_ls[0]) begin
         off_cnt <= 8'h00;
      end else if (off_cnt != 8'hFF) begin
         off_cnt <= off_cnt + 8'h01;
      end
   end
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         last_hs <= 1'b0;
      end else if (gate_hs[0] || gate_ls[0]) begin
         last_hs <= gate_hs[0];
      end
   end
   // ---
   // Assertions
   // ---
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (sys_rst);
   read_answer_a: assert property (reg_rd |=> reg_rvalid)
      else $error("no rvalid");
   answer_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
      else $error("stray rvalid");
   no_motor_a: assert property (no_motor_fault == ($past(no_motor_det) && $past(fe[7])))
      else $error("no_motor");
   kt_lock_a: assert property (kt_lock_fault == ($past(kt_abnormal_det) && $past(fe[6])))
      else $error("kt_lock");
   speed_lock_a: assert property (speed_lock_fault == ($past(speed_abnormal_det) && $past(fe[5])))
      else $error("speed_lock");
   lock_current_a: assert property (lock_current_fault == ($past(cur_hit) && $past(fe[4])))
      else $error("lock_cur");
   release_mode_a: assert property (release_hiz == ($past(sense_done) && $past(fe[0]))
      && release_brake == ($past(sense_done) && !$past(fe[0])))
      else $error("release");
   closed_stuck_a: assert property (closed_stuck_fault |-> $past(zero_cross_missing)
      && $past(cl[7]))
      else $error("cl_stuck");
   handover_gate_a: assert property ($rose(closed_loop_active) |-> $past(open_loop_active)
      && ho[7:3] != 5'h00)
      else $error("handover");
   gate_excl_a: assert property ((gate_hs & gate_ls) == '0)
      else $error("overlap");
   dead_gap_a: assert property ($rose(gate_ls[0]) && last_hs |-> int'(off_cnt) >= dt_min)
      else $error("dead time");
   cover property (reg_rvalid);
   cover property ($rose(closed_loop_active));
   cover property ($rose(gate_ls[0]) && last_hs);
endmodule
bind msp_config_bank msp_config_bank_chk #(.SPEED_W(SPEED_W), .CURR_W(CURR_W), .PHASES(PHASES))
   msp_config_bank_chk_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rvalid, .phase_current, .no_motor_det, .kt_abnormal_det, .speed_abnormal_det,
   .zero_cross_missing, .sense_done, .no_motor_fault, .kt_lock_fault, .speed_lock_fault,
   .lock_current_fault, .closed_stuck_fault, .release_brake, .release_hiz,
   .open_loop_active, .closed_loop_active, .gate_hs, .gate_ls);

//--- msp_config_bank_test.sv
// Bench for the configuration bank, with a register model.
// Assumes the host model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module msp_config_bank_test;
   logic        clk_sys = 1'b0;
   logic        sys_rst = 1'b1;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata;
   logic        reg_wr, reg_rd, reg_rvalid;
   logic [11:0] motor_speed = '0, phase_current = '0, loop_handover_threshold;
   logic        start_req = 0, stop_req = 0, no_motor_det = 0, kt_abnormal_det = 0;
   logic        speed_abnormal_det = 0, zero_cross_missing = 0, sense_done = 0;
   logic [2:0]  gate_hs_req = '0, gate_ls_req = '0, gate_hs, gate_ls;
   logic [15:0] second_order_accel, first_order_accel;
   logic        open_loop_active, closed_loop_active, accel_limit_hit, lock_current_fault;
   logic        no_motor_fault, kt_lock_fault, speed_lock_fault, closed_stuck_fault;
   logic        open_stuck_fault, mechanical_surge_enable, mechanical_surge_mode;
   logic        release_brake, release_hiz;
   int          failures = 0, checks_done = 0, n, e;
   int          mdl [int];
   logic [7:0]  a, d;
   int          acc2 [8] = '{5700, 2900, 1400, 690, 330, 160, 66, 22};
   int          acc1 [8] = '{7600, 3800, 1900, 920, 450, 210, 90, 30};
   int          thr [7] = '{1, 7, 15, 16, 24, 31, 0};

   always #2 clk_sys = ~clk_sys;

   msp_config_bank msp_config_bank_inst (.clk_sys, .sys_rst, .reg_addr, .reg_wdata, .reg_wr,
      .reg_rd, .reg_rdata, .reg_rvalid, .motor_speed, .phase_current, .start_req, .stop_req,
      .no_motor_det, .kt_abnormal_det, .speed_abnormal_det, .zero_cross_missing, .sense_done,
      .gate_hs_req, .gate_ls_req, .second_order_accel, .first_order_accel,
      .loop_handover_threshold, .open_loop_active, .closed_loop_active, .accel_limit_hit,
      .lock_current_fault, .no_motor_fault, .kt_lock_fault, .speed_lock_fault,
      .closed_stuck_fault, .open_stuck_fault, .mechanical_surge_enable,
      .mechanical_surge_mode, .release_brake, .release_hiz, .gate_hs, .gate_ls);
   msp_host_model msp_host_model_inst (.clk_sys, .reg_rdata, .reg_rvalid, .reg_addr,
      .reg_wdata, .reg_wr, .reg_rd);

   // ---
   // Shared tasks
   // ---
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic put(input logic [7:0] ad, input logic [7:0] dd);
      msp_host_model_inst.wr(ad, dd);
      if (mdl.exists(ad)) begin
         mdl[ad] = (ad == msp_pkg::ADDR_FAULT_ENABLE) ? (dd & 8'hF7) : dd;
      end
      repeat (2) @(negedge clk_sys);
   endtask
   task automatic get(input logic [7:0] ad);
      logic [7:0] rd_d;
      logic       rd_v;
      msp_host_model_inst.rd(ad, rd_d, rd_v);
      check("rvalid", 16'(rd_v), 16'h0001);
      check("rdata", 16'(rd_d), mdl.exists(ad) ? 16'(mdl[ad]) : 16'h0000);
   endtask
   task automatic stop_test();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   initial begin
      #200000;
      failures++;
      stop_test();
   end

   initial begin
      void'($urandom(85));
      for (int i = 8'h25; i <= 8'h2A; i++) mdl[i] = 0;
      repeat (20) @(negedge clk_sys);
      sys_rst = 1'b0;
      // ---
      // Reset values and read back
      // ---
      for (int i = 8'h24; i <= 8'h2B; i++) get(8'(i));
      repeat (24) begin
         a = 8'(8'h24 + $urandom_range(7));
         d = 8'($urandom);
         if (a == msp_pkg::ADDR_CLOSED_DEADTIME) d[3:0] = d[3:0] | 4'h9;
         put(a, d);
         get(a);
      end
      // ---
      // Acceleration and handover
      // ---
      for (int c = 0; c < 8; c++) begin
         put(msp_pkg::ADDR_STARTUP_ACCEL, 8'((7 - c) * 8 + c));
         check("accel2", second_order_accel, 16'(acc2[7 - c]));
         check("accel1", first_order_accel, 16'(acc1[c]));
      end
      foreach (thr[i]) begin
         put(msp_pkg::ADDR_HANDOVER_ALIGN, 8'(thr[i] * 8 + 5));
         e = thr[i] < 16 ? thr[i] * 8 : (thr[i] % 16 + 1) * 128;
         check("handover", 16'(loop_handover_threshold), 16'(e));
      end
      // ---
      // Fault enables
      // ---
      {no_motor_det, kt_abnormal_det, speed_abnormal_det} = 3'b111;
      phase_current = 12'hFFF;
      put(msp_pkg::ADDR_CURRENT_LIMIT, 8'h54);
      for (int en = 0; en < 2; en++) begin
         put(msp_pkg::ADDR_FAULT_ENABLE, en ? 8'hFF : 8'h00);
         check("no_motor", 16'(no_motor_fault), 16'(en));
         check("kt_lock", 16'(kt_lock_fault), 16'(en));
         check("speed_lock", 16'(speed_lock_fault), 16'(en));
         check("lock_cur", 16'(lock_current_fault), 16'(en));
         check("mech_surge", 16'(mechanical_surge_enable), 16'(en));
         check("mech_mode", 16'(mechanical_surge_mode), 16'(en));
         sense_done = 1'b1;
         @(negedge clk_sys);
         sense_done = 1'b0;
         check("brake", 16'(release_brake), 16'(1 - en));
         check("hiz", 16'(release_hiz), 16'(en));
      end
      // ---
      // Open loop
      // ---
      motor_speed = 12'hFFF;
      start_req = 1'b1;
      @(negedge clk_sys);
      start_req = 1'b0;
      repeat (4) @(negedge clk_sys);
      check("open", 16'(open_loop_active), 16'h0001);
      check("closed", 16'(closed_loop_active), 16'h0000);
      for (int i = 0; i < 4; i++) begin
         phase_current = 12'(i % 2 ? 1000 : 999);
         if (i > 1) phase_current = 12'(i % 2 ? 1200 : 1199);
         repeat (3) @(negedge clk_sys);
         if (i < 2) check("accel_lim", 16'(accel_limit_hit), 16'(i % 2));
         else check("lock_lim", 16'(lock_current_fault), 16'(i % 2));
      end
      put(msp_pkg::ADDR_CURRENT_LIMIT, 8'h04);
      check("accel_off", 16'(accel_limit_hit), 16'h0000);
      zero_cross_missing = 1'b1;
      put(msp_pkg::ADDR_OPEN_STUCK, 8'h08);
      check("open_stuck", 16'(open_stuck_fault), 16'h0001);
      put(msp_pkg::ADDR_OPEN_STUCK, 8'h00);
      check("open_stuck", 16'(open_stuck_fault), 16'h0000);
      // ---
      // Handover
      // ---
      motor_speed = 12'd15;
      put(msp_pkg::ADDR_HANDOVER_ALIGN, 8'h10);
      repeat (4) @(negedge clk_sys);
      check("closed", 16'(closed_loop_active), 16'h0000);
      motor_speed = 12'd16;
      repeat (4) @(negedge clk_sys);
      check("closed", 16'(closed_loop_active), 16'h0001);
      put(msp_pkg::ADDR_CLOSED_DEADTIME, 8'h89);
      check("cl_stuck", 16'(closed_stuck_fault), 16'h0001);
      put(msp_pkg::ADDR_CLOSED_DEADTIME, 8'h09);
      check("cl_stuck", 16'(closed_stuck_fault), 16'h0000);
      stop_req = 1'b1;
      @(negedge clk_sys);
      stop_req = 1'b0;
      // ---
      // Dead time
      // ---
      gate_hs_req = 3'b001;
      n = 0;
      while (gate_hs[0] !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      gate_hs_req = 3'b000;
      gate_ls_req = 3'b001;
      n = 0;
      while (gate_ls[0] !== 1'b1 && n < 300) begin
         @(negedge clk_sys);
         n++;
      end
      e = 10 * msp_pkg::DT_STEP_NS / msp_pkg::CLK_PERIOD_NS;
      check("dead_gap", 16'(n >= e - 1 && n <= e + 2), 16'h0001);
      repeat (300) begin
         @(negedge clk_sys);
         {gate_hs_req, gate_ls_req} = 6'($urandom);
      end
      stop_test();
   end
endmodule

//--- msp_dead_time.sv
// One phase leg: keeps high and low gate off together for a dead time.
// Assumes requests are synchronous to clk_sys.
`timescale 1ns/1ps
module msp_dead_time #(
   parameter int CNT_W = 8
) (
   input  wire logic             clk_sys,
   input  wire logic             sys_rst,
   input  wire logic [CNT_W-1:0] dead_cycles,
   input  wire logic             hs_req,
   input  wire logic             ls_req,
   output logic                  hs_out,
   output logic                  ls_out
);

   logic [CNT_W-1:0] gap_cnt;
   logic             want_hs;
   logic             want_ls;

   // Both requested means shoot-through: hold both off
   assign want_hs = hs_req & ~ls_req;
   assign want_ls = ls_req & ~hs_req;

   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         hs_out  <= 1'b0;
         ls_out  <= 1'b0;
         gap_cnt <= '0;
      end else if ({want_hs, want_ls} != {hs_out, ls_out}) begin
         if (hs_out | ls_out) begin
            hs_out  <= 1'b0;
            ls_out  <= 1'b0;
            gap_cnt <= dead_cycles;
         end else if (gap_cnt > 1) begin
            gap_cnt <= gap_cnt - 1'b1;
         end else begin
            hs_out  <= want_hs;
            ls_out  <= want_ls;
            gap_cnt <= '0;
         end
      end else if (gap_cnt != '0) begin
         gap_cnt <= gap_cnt - 1'b1;
      end
   end

endmodule

//--- msp_host_model.sv
// Host model: register writes and reads on the strobe port.
// Assumes strobes change at the falling edge of clk_sys.
`timescale 1ns/1ps
module msp_host_model (
   input  wire logic       clk_sys,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd
);
   initial begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr  = a;
      reg_wdata = (a == msp_pkg::ADDR_FAULT_ENABLE) ? (d & 8'hF7) : d;
      reg_wr    = 1'b1;
      @(negedge clk_sys);
      reg_wr    = 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge clk_sys);
      reg_rd   = 1'b0;
      v        = reg_rvalid;
      d        = reg_rdata;
   endtask
endmodule

//--- msp_pkg.sv
// Constants of the configuration bank.
// Assumes a serial front end turns host transactions into register strobes.
package msp_pkg;

   // ---
   // Register offsets
   // ---
   localparam logic [7:0] ADDR_STARTUP_ACCEL   = 8'h25;
   localparam logic [7:0] ADDR_HANDOVER_ALIGN  = 8'h26;
   localparam logic [7:0] ADDR_FAULT_ENABLE    = 8'h27;
   localparam logic [7:0] ADDR_CURRENT_LIMIT   = 8'h28;
   localparam logic [7:0] ADDR_CLOSED_DEADTIME = 8'h29;
   localparam logic [7:0] ADDR_OPEN_STUCK      = 8'h2A;

   // ---
   // Reset values
   // ---
   localparam logic [7:0] RST_STARTUP_ACCEL   = 8'h00;
   localparam logic [7:0] RST_HANDOVER_ALIGN  = 8'h00;
   localparam logic [7:0] RST_FAULT_ENABLE    = 8'h00;
   localparam logic [7:0] RST_CURRENT_LIMIT   = 8'h00;
   localparam logic [7:0] RST_CLOSED_DEADTIME = 8'h00;
   localparam logic [7:0] RST_OPEN_STUCK      = 8'h00;
   localparam logic [7:0] UNMAPPED_DATA       = 8'h00;

   // ---
   // Field positions
   // ---
   localparam int SECOND_ACCEL_LSB   = 3;
   localparam int FIRST_ACCEL_LSB    = 0;
   localparam int HANDOVER_LSB       = 3;
   localparam int BIT_NO_MOTOR       = 7;
   localparam int BIT_KT_LOCK        = 6;
   localparam int BIT_SPEED_LOCK     = 5;
   localparam int BIT_CURR_LOCK      = 4;
   localparam int BIT_IND_SURGE      = 3;
   localparam int BIT_MECH_SURGE     = 2;
   localparam int BIT_MECH_SURGE_MD  = 1;
   localparam int BIT_RELEASE_MODE   = 0;
   localparam int ACCEL_ILIM_LSB     = 4;
   localparam int LOCK_ILIM_LSB      = 1;
   localparam int BIT_CLOSED_STUCK   = 7;
   localparam int DEADTIME_LSB       = 0;
   localparam int BIT_OPEN_STUCK     = 3;

   // ---
   // Scaling (speed in 0.1 Hz, current in mA)
   // ---
   localparam logic [11:0] HANDOVER_STEP_LO = 12'h008;
   localparam logic [11:0] HANDOVER_STEP_HI = 12'h080;
   localparam logic [11:0] ACCEL_ILIM_STEP  = 12'h0C8;
   localparam logic [11:0] LOCK_ILIM_STEP   = 12'h190;

   // ---
   // Timing
   // ---
   localparam int CLK_PERIOD_NS  = 4;
   localparam int DT_STEP_NS     = 40;
   localparam int DT_STEP_CYC    = (DT_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_OPEN,
      ST_CLOSED
   } msp_loop_t;

endpackage
